// *** design/arpct_pkg.sv ***
package arpct_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [3:0] OFS_MODE_CONTROL = 4'h0;
  localparam logic [3:0] OFS_FLAG_STATUS = 4'h4;
  localparam logic [3:0] OFS_CLOCK_EDGE = 4'h8;
  localparam logic [3:0] OFS_LOAD_ACCESS = 4'hC;
  localparam logic [4:0] OFS_RELOAD_CAPTURE = 5'h10;
  localparam logic [4:0] OFS_COMPARE_VALUE = 5'h14;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h18;
  // ****************************************
  // mode control fields
  // ****************************************
  localparam int MC_LOAD_STROBE = 7;
  localparam int MC_COUNT_EN = 6;
  localparam int MC_PWM_OE = 5;
  localparam int MC_EDGE_IE = 4;
  localparam int MC_CMP_IE = 3;
  localparam int MC_OVF_IE = 2;
  localparam int MC_MODE_HI = 1;
  localparam int MC_MODE_LO = 0;
  // ****************************************
  // flag status fields
  // ****************************************
  localparam int FS_EDGE = 2;
  localparam int FS_CMP = 1;
  localparam int FS_OVF = 0;
  // ****************************************
  // clock / edge config fields
  // ****************************************
  localparam int CE_DIV_HI = 7;
  localparam int CE_DIV_LO = 5;
  localparam int CE_POL = 3;
  localparam int CE_EDGE_EN = 2;
  localparam int CE_CLK_HI = 1;
  localparam int CE_CLK_LO = 0;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_CLOCK_EDGE = 8'h00;
  localparam logic [7:0] RST_COUNTER = 8'h00;
  localparam logic [7:0] RST_RELOAD = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'h00;
  localparam logic [1:0] RST_DIV3 = 2'h0;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_DIV3_COUNT = 3;
  localparam logic [1:0] DIV3_LAST = 2'(CLK_DIV3_COUNT - 1);
  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {
    ARPCT_AUTO_RELOAD,
    ARPCT_CAPTURE,
    ARPCT_CAPTURE_RESET,
    ARPCT_EXT_LOAD
  } arpct_mode_t;
  typedef enum logic [1:0] {
    ARPCT_CLK_INT,
    ARPCT_CLK_DIV3,
    ARPCT_CLK_PIN,
    ARPCT_CLK_RSVD
  } arpct_clk_t;
endpackage

// *** design/arpct_timer.sv ***
// Behaviour
// - 8-bit counter increments on prescaled clock
// - counter loads from reload/capture register
// - clock is internal, internal/3, or pin
// - 7-bit prescaler, tap gives 2^n division
// - enable clear freezes prescaler and counter
// - reset clears the counter
// - load access write loads, read shows count
// - any counter initialization clears the prescaler
// - auto-reload overflow reloads, sets pwm pin
// - auto-reload compare match clears pwm pin
// - overflow sets sticky flag, gated interrupt
// - compare match sets sticky flag, gated interrupt
// - auto-reload accepts all three clock sources
// - capture edge copies counter, sets edge flag
// - other modes: overflow sets, compare clears pin
// - capture-reset edge clears counter and prescaler
// - external-load edge copies reload into counter
// - interrupt request wakes wait; stop needs pin
// - mode code 00/01/10/11 selects four modes
// - edge enable bit, polarity bit picks edge
// - clock code 00 int, 01 div3, 10 pin
// - flags clear on zero write, one ignored
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module arpct_timer (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic timer_in_pin,
  output logic pwm_out_pin,
  output logic pwm_out_oe,
  output logic irq_request,
  output logic stop_wake_capable
);
  // ****************************************
  // registers
  // ****************************************
  logic [6:0] mode_control_reg;
  logic [2:0] flag_status_reg;
  logic [7:0] clock_edge_config_reg;
  logic [7:0] reload_capture_reg;
  logic [7:0] compare_value_reg;
  logic [7:0] up_counter;
  logic [6:0] tap_prescaler;
  logic [1:0] div3_cnt;
  logic pin_q;
  logic src_q;
  logic tick_q;
  logic [7:0] next_up_counter;

  // local names for the package encodings
  typedef arpct_pkg::arpct_mode_t arpct_mode_t;
  typedef arpct_pkg::arpct_clk_t arpct_clk_t;
  localparam arpct_mode_t ARPCT_AUTO_RELOAD = arpct_pkg::ARPCT_AUTO_RELOAD;
  localparam arpct_mode_t ARPCT_CAPTURE = arpct_pkg::ARPCT_CAPTURE;
  localparam arpct_mode_t ARPCT_CAPTURE_RESET = arpct_pkg::ARPCT_CAPTURE_RESET;
  localparam arpct_mode_t ARPCT_EXT_LOAD = arpct_pkg::ARPCT_EXT_LOAD;
  localparam arpct_clk_t ARPCT_CLK_INT = arpct_pkg::ARPCT_CLK_INT;
  localparam arpct_clk_t ARPCT_CLK_DIV3 = arpct_pkg::ARPCT_CLK_DIV3;
  localparam arpct_clk_t ARPCT_CLK_PIN = arpct_pkg::ARPCT_CLK_PIN;

  arpct_mode_t mode;
  arpct_clk_t clk_sel;
  logic count_clock_enable, load_strobe_bit;
  logic edge_detect_enable, edge_polarity_sel;
  logic [2:0] div_sel;
  logic wr_ok, wr_mode, wr_flags, wr_cfg, wr_load, wr_reload, wr_cmp;
  logic src_level, src_rise, tick, pin_edge, active_edge;
  logic overflow, cmp_match, init_load;

  // ****************************************
  // decode
  // ****************************************
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  assign mode = arpct_mode_t'(mode_control_reg[1:0]);
  assign count_clock_enable = mode_control_reg[arpct_pkg::MC_COUNT_EN];
  assign clk_sel = arpct_clk_t'(clock_edge_config_reg[1:0]);
  assign edge_detect_enable = clock_edge_config_reg[arpct_pkg::CE_EDGE_EN];
  assign edge_polarity_sel = clock_edge_config_reg[arpct_pkg::CE_POL];
  assign div_sel = clock_edge_config_reg[7:5];

  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wr_mode = wr_ok && hit(avs_address, 5'(arpct_pkg::OFS_MODE_CONTROL));
  assign wr_flags = wr_ok && hit(avs_address, 5'(arpct_pkg::OFS_FLAG_STATUS));
  assign wr_cfg = wr_ok && hit(avs_address, 5'(arpct_pkg::OFS_CLOCK_EDGE));
  assign wr_load = wr_ok && hit(avs_address, 5'(arpct_pkg::OFS_LOAD_ACCESS));
  assign wr_reload = wr_ok && hit(avs_address, arpct_pkg::OFS_RELOAD_CAPTURE);
  assign wr_cmp = wr_ok && hit(avs_address, arpct_pkg::OFS_COMPARE_VALUE);
  assign load_strobe_bit = wr_mode &&
    avs_writedata[arpct_pkg::MC_LOAD_STROBE];

  // ****************************************
  // clock source and prescaler
  // ****************************************
  always_comb begin
    case (clk_sel)
      ARPCT_CLK_INT: src_level = 1'b1;
      ARPCT_CLK_DIV3: src_level = (div3_cnt == arpct_pkg::DIV3_LAST);
      ARPCT_CLK_PIN: src_level = timer_in_pin;
      default: src_level = 1'b0;
    endcase
  end
  // internal source pulses every cycle; pin uses its rising edge
  assign src_rise = (clk_sel == ARPCT_CLK_PIN) ? (src_level && !src_q) :
    src_level;
  assign tick = count_clock_enable && src_rise && tick_q;

  always_comb begin
    tick_q = 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(div_sel)) begin
        tick_q = tick_q & tap_prescaler[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div3_cnt <= arpct_pkg::RST_DIV3;
    end else if (div3_cnt == arpct_pkg::DIV3_LAST) begin
      div3_cnt <= 2'h0;
    end else begin
      div3_cnt <= div3_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      src_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      src_q <= src_level;
      pin_q <= timer_in_pin;
    end
  end

  // ****************************************
  // edge detect
  // ****************************************
  assign pin_edge = edge_polarity_sel ? (pin_q && !timer_in_pin) :
    (!pin_q && timer_in_pin);
  assign active_edge = edge_detect_enable && pin_edge;

  // ****************************************
  // counter
  // ****************************************
  assign overflow = tick && (up_counter == 8'hFF);
  assign cmp_match = tick && (next_up_counter == compare_value_reg);
  assign init_load = load_strobe_bit || wr_load ||
    (active_edge && mode inside {ARPCT_CAPTURE_RESET, ARPCT_EXT_LOAD});

  always_comb begin
    next_up_counter = up_counter;
    if (tick) begin
      if (overflow && mode == ARPCT_AUTO_RELOAD) begin
        next_up_counter = reload_capture_reg;
      end else begin
        next_up_counter = up_counter + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      up_counter <= arpct_pkg::RST_COUNTER;
    end else if (wr_load) begin
      up_counter <= avs_writedata[7:0];
    end else if (load_strobe_bit) begin
      up_counter <= reload_capture_reg;
    end else if (active_edge && mode == ARPCT_CAPTURE_RESET) begin
      up_counter <= 8'h00;
    end else if (active_edge && mode == ARPCT_EXT_LOAD) begin
      up_counter <= reload_capture_reg;
    end else begin
      up_counter <= next_up_counter;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tap_prescaler <= 7'h00;
    end else if (init_load) begin
      tap_prescaler <= 7'h00;
    end else if (count_clock_enable && src_rise) begin
      tap_prescaler <= tap_prescaler + 7'h01;
    end
  end

  // ****************************************
  // pwm output
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pwm_out_pin <= 1'b0;
    end else if (overflow) begin
      pwm_out_pin <= 1'b1;
    end else if (cmp_match) begin
      pwm_out_pin <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pwm_out_oe <= 1'b0;
    end else begin
      pwm_out_oe <= mode_control_reg[arpct_pkg::MC_PWM_OE];
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_control_reg <= arpct_pkg::RST_MODE_CONTROL[6:0];
      clock_edge_config_reg <= arpct_pkg::RST_CLOCK_EDGE;
      compare_value_reg <= arpct_pkg::RST_COMPARE;
    end else begin
      if (wr_mode) begin
        mode_control_reg <= avs_writedata[6:0];
      end
      if (wr_cfg) begin
        clock_edge_config_reg <= avs_writedata[7:0] & 8'hEF;
      end
      if (wr_cmp) begin
        compare_value_reg <= avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reload_capture_reg <= arpct_pkg::RST_RELOAD;
    end else if (active_edge &&
                 mode inside {ARPCT_CAPTURE, ARPCT_CAPTURE_RESET}) begin
      reload_capture_reg <= up_counter;
    end else if (wr_reload) begin
      reload_capture_reg <= avs_writedata[7:0];
    end
  end

  // ****************************************
  // flags, set wins over clear
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flag_status_reg <= 3'h0;
    end else begin
      flag_status_reg[arpct_pkg::FS_OVF] <= overflow ||
        (flag_status_reg[arpct_pkg::FS_OVF] &&
         !(wr_flags && !avs_writedata[arpct_pkg::FS_OVF]));
      flag_status_reg[arpct_pkg::FS_CMP] <= cmp_match ||
        (flag_status_reg[arpct_pkg::FS_CMP] &&
         !(wr_flags && !avs_writedata[arpct_pkg::FS_CMP]));
      flag_status_reg[arpct_pkg::FS_EDGE] <=
        (active_edge && mode != ARPCT_AUTO_RELOAD) ||
        (flag_status_reg[arpct_pkg::FS_EDGE] &&
         !(wr_flags && !avs_writedata[arpct_pkg::FS_EDGE]));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_request <= 1'b0;
      stop_wake_capable <= 1'b0;
    end else begin
      irq_request <= |(flag_status_reg & mode_control_reg[4:2]);
      stop_wake_capable <= (clk_sel == ARPCT_CLK_PIN);
    end
  end

  // ****************************************
  // bus slave: one wait state
  // ****************************************
  // low for one cycle after a request has waited one cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read) begin
      case (avs_address)
        5'(arpct_pkg::OFS_MODE_CONTROL):
          avs_readdata <= {25'h0, mode_control_reg};
        5'(arpct_pkg::OFS_FLAG_STATUS):
          avs_readdata <= {29'h0, flag_status_reg};
        5'(arpct_pkg::OFS_CLOCK_EDGE):
          avs_readdata <= {24'h0, clock_edge_config_reg};
        5'(arpct_pkg::OFS_LOAD_ACCESS):
          avs_readdata <= {24'h0, up_counter};
        arpct_pkg::OFS_RELOAD_CAPTURE:
          avs_readdata <= {24'h0, reload_capture_reg};
        arpct_pkg::OFS_COMPARE_VALUE:
          avs_readdata <= {24'h0, compare_value_reg};
        arpct_pkg::OFS_IRQ_STATUS:
          avs_readdata <= {31'h0, irq_request};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  reset_clear_a: assert property (@(posedge clk_sys)
    reset |=> up_counter == 8'h00) else $error("counter not cleared");
  count_step_a: assert property (@(posedge clk_sys) disable iff (reset)
    tick && !init_load && up_counter != 8'hFF |=>
    up_counter == $past(up_counter) + 8'h01) else $error("bad increment");
  freeze_a: assert property (@(posedge clk_sys) disable iff (reset)
    !count_clock_enable && !init_load |=>
    $stable(up_counter) && $stable(tap_prescaler)) else $error("not frozen");
  load_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    wr_load |=> up_counter == $past(avs_writedata[7:0]) &&
    tap_prescaler == 7'h00) else $error("load access failed");
  reload_ovf_a: assert property (@(posedge clk_sys) disable iff (reset)
    overflow && !init_load && mode == ARPCT_AUTO_RELOAD |=>
    up_counter == $past(reload_capture_reg) && pwm_out_pin)
    else $error("reload missing");
  wrap_ovf_a: assert property (@(posedge clk_sys) disable iff (reset)
    overflow && !init_load && mode != ARPCT_AUTO_RELOAD |=>
    up_counter == 8'h00) else $error("wrap missing");
  cmp_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
    cmp_match && !overflow |=> !pwm_out_pin &&
    flag_status_reg[arpct_pkg::FS_CMP])
    else $error("pwm not cleared");
  ovf_sticky_a: assert property (@(posedge clk_sys) disable iff (reset)
    overflow |=> flag_status_reg[arpct_pkg::FS_OVF])
    else $error("ovf flag missing");
  flag_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
    flag_status_reg[arpct_pkg::FS_CMP] && !wr_flags |=>
    flag_status_reg[arpct_pkg::FS_CMP]) else $error("cmp flag lost");
  capture_a: assert property (@(posedge clk_sys) disable iff (reset)
    active_edge && mode == ARPCT_CAPTURE |=>
    reload_capture_reg == $past(up_counter) &&
    flag_status_reg[arpct_pkg::FS_EDGE]) else $error("capture failed");
  cap_reset_a: assert property (@(posedge clk_sys) disable iff (reset)
    active_edge && mode == ARPCT_CAPTURE_RESET && !wr_load &&
    !load_strobe_bit |=> up_counter == 8'h00)
    else $error("capture reset failed");
  ext_load_a: assert property (@(posedge clk_sys) disable iff (reset)
    active_edge && mode == ARPCT_EXT_LOAD && !wr_load &&
    !load_strobe_bit |=> up_counter == $past(reload_capture_reg))
    else $error("external load failed");
  irq_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
    flag_status_reg[arpct_pkg::FS_OVF] &&
    mode_control_reg[arpct_pkg::MC_OVF_IE] |=> irq_request)
    else $error("irq missing");
  flag_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
    wr_flags && !avs_writedata[arpct_pkg::FS_OVF] && !overflow |=>
    !flag_status_reg[arpct_pkg::FS_OVF])
    else $error("flag clear failed");
  pwm_cycle_c: cover property (@(posedge clk_sys) disable iff (reset)
    overflow ##[1:300] cmp_match);
  capture_c: cover property (@(posedge clk_sys) disable iff (reset)
    active_edge && mode == ARPCT_CAPTURE_RESET);
  ext_load_c: cover property (@(posedge clk_sys) disable iff (reset)
    active_edge && mode == ARPCT_EXT_LOAD);
  set_clear_c: cover property (@(posedge clk_sys) disable iff (reset)
    overflow && wr_flags && !avs_writedata[arpct_pkg::FS_OVF]);
endmodule
`default_nettype wire

// *** tb/arpct_pin_source.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// far-side source on the timer input pin
// ****************************************
module arpct_pin_source (
  input wire logic clk_sys,
  input wire logic run,
  input wire logic [7:0] half,
  input wire logic set_level,
  output logic timer_in_pin
);
  logic [7:0] cnt = 8'h00;
  initial timer_in_pin = 1'b0;
  // square wave of half period half while run, else follows set_level
  always @(posedge clk_sys) begin
    if (run) begin
      cnt <= (cnt + 8'h01 >= half) ? 8'h00 : cnt + 8'h01;
      if (cnt + 8'h01 >= half) begin
        timer_in_pin <= ~timer_in_pin;
      end
    end else begin
      cnt <= 8'h00;
      timer_in_pin <= set_level;
    end
  end
endmodule
`default_nettype wire

// *** tb/arpct_timer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_fail++; $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module arpct_timer_tb;
  // ****************************************
  // signals
  // ****************************************
  localparam int CEIL = 60000;
  localparam logic [4:0] A_MC = 5'(arpct_pkg::OFS_MODE_CONTROL);
  localparam logic [4:0] A_FS = 5'(arpct_pkg::OFS_FLAG_STATUS);
  localparam logic [4:0] A_CE = 5'(arpct_pkg::OFS_CLOCK_EDGE);
  localparam logic [4:0] A_LA = 5'(arpct_pkg::OFS_LOAD_ACCESS);
  localparam logic [4:0] A_RC = arpct_pkg::OFS_RELOAD_CAPTURE;
  localparam logic [4:0] A_CP = arpct_pkg::OFS_COMPARE_VALUE;
  localparam logic [4:0] A_IS = arpct_pkg::OFS_IRQ_STATUS;
  localparam logic [7:0] B_LD = 8'h01 << arpct_pkg::MC_LOAD_STROBE;
  localparam logic [7:0] B_EN = 8'h01 << arpct_pkg::MC_COUNT_EN;
  localparam logic [7:0] B_OE = 8'h01 << arpct_pkg::MC_PWM_OE;
  localparam logic [7:0] B_EI = 8'h01 << arpct_pkg::MC_EDGE_IE;
  localparam logic [7:0] B_CP = 8'h01 << arpct_pkg::MC_CMP_IE;
  localparam logic [7:0] B_OV = 8'h01 << arpct_pkg::MC_OVF_IE;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic timer_in_pin;
  logic pwm_out_pin;
  logic pwm_out_oe;
  logic irq_request;
  logic stop_wake_capable;
  logic run = 1'b0;
  logic [7:0] half = 8'h05;
  logic set_level = 1'b0;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed = 32'h9900aa57;
  int w;
  int hi;
  logic [2:0] dv;
  logic [7:0] rd, v, r, c;
  logic [4:0] regs [8] = '{A_MC, A_FS, A_CE, A_LA, A_RC, A_CP, A_IS, 5'h1C};
  arpct_timer uut (
    .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer_in_pin(timer_in_pin), .pwm_out_pin(pwm_out_pin),
    .pwm_out_oe(pwm_out_oe), .irq_request(irq_request),
    .stop_wake_capable(stop_wake_capable)
  );
  arpct_pin_source far_end (
    .clk_sys(clk_sys), .run(run), .half(half), .set_level(set_level),
    .timer_in_pin(timer_in_pin)
  );
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      n_fail++;
      test_done();
    end
  end
  // ****************************************
  // bus tasks and expectations
  // ****************************************
  task automatic av_wr(input logic [4:0] a, input logic [7:0] d,
                       input logic [3:0] be = 4'hF);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    avs_write <= 1'b0;
  endtask
  task automatic av_rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
  endtask
  task automatic pin(input logic lv);
    set_level <= lv;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic wait_pwm(input logic lv);
    @(posedge clk_sys);
    while (pwm_out_pin === lv) @(posedge clk_sys);
    while (pwm_out_pin !== lv) @(posedge clk_sys);
  endtask
  function automatic int exp_rate(input int s, input int d, input int n);
    int b;
    b = (s == 0) ? n + 3 : (s == 1) ? (n + 3) / 3 : (s == 2) ? (n + 3) / 10 : 0;
    return b >> d;
  endfunction
  function automatic logic near(input int a, input int b, input int t);
    return (a - b <= t) && (b - a <= t);
  endfunction
  task test_done();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (regs[i]) begin
      av_rd(regs[i], rd);
      `CHK("reset value", 8'h00, rd)
    end
    av_wr(A_CP, 8'h77, 4'h0);
    av_rd(A_CP, rd);
    `CHK("no byteenable", 8'h00, rd)
    v = 8'($random(seed));
    av_wr(A_LA, v);
    repeat (20) @(posedge clk_sys);
    av_rd(A_LA, rd);
    `CHK("load access", v, rd)
    for (int s = 0; s < 4; s++) begin
      dv = 3'($random(seed)) & 3'h3;
      run <= (s == 2);
      av_wr(A_MC, 8'h00);
      av_wr(A_CE, {dv, 3'h0, 2'(s)});
      av_wr(A_LA, 8'h00);
      av_wr(A_MC, B_EN);
      repeat (120) @(posedge clk_sys);
      av_wr(A_MC, 8'h00);
      av_rd(A_LA, rd);
      `CHK("rate", 1'b1, near(rd, exp_rate(s, dv, 120), (s == 3) ? 0 : 2))
      `CHK("wake", 1'(s == 2), stop_wake_capable)
    end
    run <= 1'b0;
    r = 8'($random(seed));
    av_wr(A_RC, r);
    av_wr(A_MC, B_LD | B_OE);
    av_rd(A_LA, rd);
    `CHK("strobe load", r, rd)
    `CHK("pwm oe", 1'b1, pwm_out_oe)
    av_rd(A_MC, rd);
    `CHK("strobe reads 0", B_OE, rd)
    for (int k = 0; k < 2; k++) begin
      r = 8'($random(seed)) & 8'h7F;
      c = r + 8'h10 + (8'($random(seed)) & 8'h3F);
      av_wr(A_FS, 8'h00);
      av_wr(A_CE, 8'h00);
      av_wr(A_RC, r);
      av_wr(A_CP, c);
      av_wr(A_MC, B_LD | B_EN | B_OE | B_OV);
      wait_pwm(1'b1);
      w = cyc;
      wait_pwm(1'b0);
      hi = cyc - w;
      wait_pwm(1'b1);
      `CHK("period", 256 - int'(r), cyc - w)
      `CHK("duty", 1'b1, near(hi, int'(c) - int'(r), 1))
      `CHK("ovf irq", 1'b1, irq_request)
      av_wr(A_MC, B_OV);
      av_rd(A_FS, rd);
      `CHK("flags", 8'h03, rd)
      av_wr(A_FS, 8'h06);
      av_rd(A_FS, rd);
      `CHK("clear ovf", 8'h02, rd)
      `CHK("irq masked", 1'b0, irq_request)
      av_wr(A_MC, B_CP);
      av_rd(A_IS, rd);
      `CHK("cmp irq", 8'h01, rd)
      `CHK("irq pin", 1'b1, irq_request)
    end
    av_wr(A_FS, 8'h00);
    v = 8'($random(seed));
    av_wr(A_LA, v);
    av_wr(A_RC, 8'h00);
    av_wr(A_MC, 8'h01 | B_EI);
    av_wr(A_CE, 8'h0C);
    pin(1'b1);
    av_rd(A_RC, rd);
    `CHK("wrong edge", 8'h00, rd)
    pin(1'b0);
    av_rd(A_RC, rd);
    `CHK("capture", v, rd)
    av_rd(A_FS, rd);
    `CHK("edge flag", 8'h04, rd)
    `CHK("edge irq", 1'b1, irq_request)
    av_wr(A_CE, 8'h08);
    av_wr(A_LA, ~v);
    pin(1'b1);
    pin(1'b0);
    av_rd(A_RC, rd);
    `CHK("edge off", v, rd)
    r = 8'($random(seed));
    av_wr(A_RC, r);
    av_wr(A_LA, 8'h00);
    av_wr(A_MC, 8'h03);
    av_wr(A_CE, 8'h04);
    pin(1'b1);
    av_rd(A_LA, rd);
    `CHK("edge load", r, rd)
    pin(1'b0);
    av_wr(A_MC, 8'h02 | B_EN);
    half <= 8'h14;
    run <= 1'b1;
    repeat (200) @(posedge clk_sys);
    av_wr(A_CE, 8'h00);
    av_wr(A_MC, 8'h02);
    run <= 1'b0;
    av_rd(A_RC, rd);
    `CHK("interval", 1'b1, near(rd, 39, 2))
    av_wr(A_FS, 8'h00);
    av_wr(A_RC, 8'h40);
    av_wr(A_CP, 8'h80);
    av_wr(A_LA, 8'hFE);
    av_wr(A_MC, 8'h01 | B_EN);
    repeat (8) @(posedge clk_sys);
    av_wr(A_MC, 8'h01);
    av_rd(A_LA, rd);
    `CHK("wrap", 1'b1, rd < 8'h10)
    `CHK("pwm set", 1'b1, pwm_out_pin)
    av_rd(A_FS, rd);
    `CHK("ovf only", 8'h01, rd)
    test_done();
  end
endmodule
`default_nettype wire
